// [pkg/fods_pkg.sv]
// constants, register map and state type for the floating origin /
// direct start command block; assumes a 10 MHz system clock
package fods_pkg;
  localparam int AXES = 2;
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int DWELL_UNIT_MS = 1;
  localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000 * DWELL_UNIT_MS;
  localparam logic [24:0] STEP_WRAP = 25'h098_9680;
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_AXIS = 8'h04;
  localparam logic [7:0] OFS_TPOS = 8'h08;
  localparam logic [7:0] OFS_TSPD = 8'h0c;
  localparam logic [7:0] OFS_DWELL = 8'h10;
  localparam logic [7:0] OFS_AUX = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_ERRCODE = 8'h20;
  localparam logic [7:0] OFS_POS_X = 8'h24;
  localparam logic [7:0] OFS_POS_Y = 8'h28;
  localparam logic [7:0] OFS_AUX_OUT = 8'h2c;
  localparam logic [7:0] OFS_BIAS = 8'h30;
  localparam logic [7:0] OFS_LIMIT = 8'h34;
  // command register bits, levels whose rising edge acts
  localparam int CMD_FLT_BIT = 0;
  localparam int CMD_DST_BIT = 1;
  localparam int CMD_CLR_BIT = 2;
  localparam int CMD_STOP_BIT = 3;
  // control word fields
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_INC_BIT = 4;
  localparam int CTRL_ACC_LSB = 5;
  // status fields, per axis at AX_BASE + axis * AX_STRIDE
  localparam int ST_INSTR_ERR_BIT = 0;
  localparam int AX_BASE = 4;
  localparam int AX_STRIDE = 4;
  localparam int AX_BUSY = 0;
  localparam int AX_ERR = 1;
  localparam int AX_FIN = 2;
  localparam int AX_ORG = 3;
  localparam int ACC_BASE = 16;
  localparam logic [7:0] ERR_NO_ORIGIN = 8'he0;
  localparam logic [31:0] BIAS_RESET = 32'h0000_0001;
  localparam logic [31:0] LIMIT_RESET = 32'h0001_86a0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MOVE = 4'h2,
    ST_DWELL = 4'h4,
    ST_SPEED = 4'h8
  } fods_state_type;
endpackage : fods_pkg

// [src/fods_top.sv]
// two-axis floating origin and direct start command unit, AXI4-Lite
// assumes commands come as register levels and scan_tick marks scan ends
//
// Contract
// RULE1: floating origin on rising edge, selected axis
// RULE2: floating origin zeroes position, sets origin bit
// RULE3: bad axis select sets instruction error, no run
// RULE4: bad axis select leaves axis error clear
// RULE5: direct start begins on rising edge
// RULE6: direct start uses operand position, speed, dwell, aux
// RULE7: control bit0 picks position or speed control
// RULE8: control bit4 picks absolute or incremental
// RULE9: control bits6:5 pick acceleration set one-four
// RULE10: direct start always single end-pattern move; speed control here runs until stop, with no finish
// RULE11: bias and limit speed from stored parameters
// RULE12: no origin gives error 224, no motion
// RULE13: move, stop, dwell, then finish with aux
// RULE14: finished flag high for exactly one scan
// RULE15: controller commands only idle error-free axes
// RULE16: controller clears errors before floating origin
`timescale 1ns/1ps
`default_nettype none
module fods_top
  import fods_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic scan_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] step_pulse,
  output logic [1:0] step_dir
);
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [7:0] aw_addr;
  logic aw_hold;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_hold;
  logic [31:0] cmd;
  logic [31:0] cmd_prev;
  logic [31:0] axis_select;
  logic [31:0] target_position_operand;
  logic [31:0] target_speed_operand;
  logic [31:0] dwell_time_operand;
  logic [31:0] aux_code_operand;
  logic [31:0] control_word_operand;
  logic [31:0] bias_speed;
  logic [31:0] speed_limit;
  logic instruction_error_flag;
  logic [AXES-1:0] busy;
  logic [AXES-1:0] axis_err;
  logic [AXES-1:0] fin;
  logic [AXES-1:0] origin;
  logic [7:0] err_code [AXES];
  logic signed [31:0] cur_pos [AXES];
  logic [15:0] aux_out [AXES];
  logic [1:0] acc_set [AXES];

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_en = ce & aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_cmd = wr_en & (aw_addr == OFS_CMD);
  wire wr_known = (aw_addr == OFS_CMD) | (aw_addr == OFS_AXIS) |
      (aw_addr == OFS_TPOS) | (aw_addr == OFS_TSPD) |
      (aw_addr == OFS_DWELL) | (aw_addr == OFS_AUX) |
      (aw_addr == OFS_CTRL) | (aw_addr == OFS_BIAS) |
      (aw_addr == OFS_LIMIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= 32'h0000_0000;
      axis_select <= 32'h0000_0000;
      target_position_operand <= 32'h0000_0000;
      target_speed_operand <= 32'h0000_0000;
      dwell_time_operand <= 32'h0000_0000;
      aux_code_operand <= 32'h0000_0000;
      control_word_operand <= 32'h0000_0000;
      bias_speed <= BIAS_RESET;
      speed_limit <= LIMIT_RESET;
    end else if (wr_en) begin
      case (aw_addr)
        OFS_CMD: cmd <= merge(cmd, w_data, w_strb);
        OFS_AXIS: axis_select <= merge(axis_select, w_data, w_strb);
        OFS_TPOS: target_position_operand <=
            merge(target_position_operand, w_data, w_strb);
        OFS_TSPD: target_speed_operand <=
            merge(target_speed_operand, w_data, w_strb);
        OFS_DWELL: dwell_time_operand <=
            merge(dwell_time_operand, w_data, w_strb) & 32'h0000_ffff;
        OFS_AUX: aux_code_operand <=
            merge(aux_code_operand, w_data, w_strb) & 32'h0000_ffff;
        OFS_CTRL: control_word_operand <=
            merge(control_word_operand, w_data, w_strb) & 32'h0000_ffff;
        OFS_BIAS: bias_speed <= merge(bias_speed, w_data, w_strb);
        OFS_LIMIT: speed_limit <= merge(speed_limit, w_data, w_strb);
        default: cmd <= cmd;
      endcase
    end
  end

  // command edges; previous level kept only when the clock is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_prev <= 32'h0000_0000;
    end else if (ce) begin
      cmd_prev <= cmd;
    end
  end
  wire [31:0] cmd_rise = cmd & ~cmd_prev;
  wire flt_rise = ce & cmd_rise[CMD_FLT_BIT]; // [RULE1]
  wire dst_rise = ce & cmd_rise[CMD_DST_BIT]; // [RULE5]
  wire clr_rise = ce & cmd_rise[CMD_CLR_BIT];
  wire stop_rise = ce & cmd_rise[CMD_STOP_BIT];
  wire ax_ok = (axis_select[15:1] == 15'h0000); // [RULE3]
  wire ax_idx = axis_select[0];
  wire bad_cmd = (flt_rise | dst_rise) & ~ax_ok; // [RULE3]

  // set wins over the clear arriving in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instruction_error_flag <= 1'b0;
    end else if (bad_cmd) begin
      instruction_error_flag <= 1'b1; // [RULE3]
    end else if (clr_rise) begin
      instruction_error_flag <= 1'b0;
    end
  end

  wire dst_speed_mode = control_word_operand[CTRL_SPEED_BIT]; // [RULE7]
  wire dst_incremental = control_word_operand[CTRL_INC_BIT]; // [RULE8]
  wire [1:0] dst_acc = control_word_operand[CTRL_ACC_LSB +: 2]; // [RULE9]
  wire [31:0] spd_lo = (target_speed_operand < bias_speed) ?
      bias_speed : target_speed_operand;
  wire [31:0] spd_eff = (spd_lo > speed_limit) ? speed_limit : spd_lo;

  for (genvar a = 0; a < AXES; a++) begin : g_axis
    fods_state_type state;
    logic signed [31:0] tgt;
    logic [16:0] spd;
    logic [23:0] acc;
    logic [15:0] dwell_left;
    logic [15:0] aux_hold;
    logic [31:0] ms_cnt;
    logic fin_pend;
    wire sel = ax_ok & (ax_idx == 1'(a)); // [RULE4]
    wire go_flt = flt_rise & sel & (state == ST_IDLE); // [RULE1]
    wire go_dst = dst_rise & sel & (state == ST_IDLE) & ~axis_err[a];
    wire no_org = go_dst & ~origin[a]; // [RULE12]
    wire [31:0] tgt_abs = dst_incremental ?
        32'(cur_pos[a] + $signed(target_position_operand)) :
        target_position_operand; // [RULE8]
    wire [24:0] acc_sum = {1'b0, acc} + {8'h00, spd};
    wire step_now = (acc_sum >= STEP_WRAP);
    wire [24:0] acc_wrap = acc_sum - STEP_WRAP;
    wire at_tgt = (cur_pos[a] == tgt);
    wire fwd = (state == ST_SPEED) ? step_dir[a] : (tgt > cur_pos[a]);
    assign busy[a] = (state != ST_IDLE);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        state <= ST_IDLE;
        tgt <= 32'sh0000_0000;
        spd <= 17'h0_0000;
        acc <= 24'h00_0000;
        dwell_left <= 16'h0000;
        aux_hold <= 16'h0000;
        ms_cnt <= 32'h0000_0000;
        fin_pend <= 1'b0;
        fin[a] <= 1'b0;
        origin[a] <= 1'b0;
        axis_err[a] <= 1'b0;
        err_code[a] <= 8'h00;
        cur_pos[a] <= 32'sh0000_0000;
        aux_out[a] <= 16'h0000;
        acc_set[a] <= 2'h0;
        step_pulse[a] <= 1'b0;
        step_dir[a] <= 1'b0;
      end else if (ce) begin
        step_pulse[a] <= 1'b0;
        if (scan_tick) begin
          fin[a] <= fin_pend; // [RULE14]
          fin_pend <= 1'b0;
        end
        if (no_org) begin
          axis_err[a] <= 1'b1; // [RULE12]
          err_code[a] <= ERR_NO_ORIGIN;
        end else if (clr_rise & sel) begin
          axis_err[a] <= 1'b0;
          err_code[a] <= 8'h00;
        end
        case (state)
          ST_IDLE: begin
            if (go_flt) begin
              cur_pos[a] <= 32'sh0000_0000; // [RULE2]
              origin[a] <= 1'b1; // [RULE2]
            end else if (go_dst & origin[a]) begin
              tgt <= tgt_abs; // [RULE6]
              spd <= spd_eff[16:0]; // [RULE11]
              dwell_left <= dwell_time_operand[15:0]; // [RULE6]
              aux_hold <= aux_code_operand[15:0]; // [RULE6]
              acc_set[a] <= dst_acc; // [RULE9]
              acc <= 24'h00_0000;
              step_dir[a] <= ~target_position_operand[31];
              state <= dst_speed_mode ? ST_SPEED : ST_MOVE; // [RULE7]
            end
          end
          ST_MOVE: begin
            if (at_tgt) begin
              ms_cnt <= 32'h0000_0000;
              state <= ST_DWELL; // [RULE13]
            end else begin
              acc <= step_now ? acc_wrap[23:0] : acc_sum[23:0];
              step_dir[a] <= fwd;
              if (step_now) begin
                step_pulse[a] <= 1'b1;
                cur_pos[a] <= fwd ? cur_pos[a] + 32'sd1 :
                    cur_pos[a] - 32'sd1;
              end
            end
          end
          ST_DWELL: begin
            if (dwell_left == 16'h0000) begin
              fin_pend <= 1'b1; // [RULE13]
              aux_out[a] <= aux_hold; // [RULE13]
              state <= ST_IDLE; // [RULE10]
            end else if (ms_cnt == 32'(MS_CYCLES - 1)) begin
              ms_cnt <= 32'h0000_0000;
              dwell_left <= dwell_left - 16'h0001;
            end else begin
              ms_cnt <= ms_cnt + 32'h0000_0001;
            end
          end
          ST_SPEED: begin
            // speed control has no end point; only stop ends it
            acc <= step_now ? acc_wrap[23:0] : acc_sum[23:0];
            if (step_now) begin
              step_pulse[a] <= 1'b1;
              cur_pos[a] <= fwd ? cur_pos[a] + 32'sd1 :
                  cur_pos[a] - 32'sd1;
            end
            if (stop_rise & sel) begin
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[ST_INSTR_ERR_BIT] = instruction_error_flag;
    for (int a = 0; a < AXES; a++) begin
      status[AX_BASE + a*AX_STRIDE + AX_BUSY] = busy[a];
      status[AX_BASE + a*AX_STRIDE + AX_ERR] = axis_err[a];
      status[AX_BASE + a*AX_STRIDE + AX_FIN] = fin[a];
      status[AX_BASE + a*AX_STRIDE + AX_ORG] = origin[a];
      status[ACC_BASE + a*2 +: 2] = acc_set[a];
    end
  end

  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      OFS_CMD: rd_val = cmd;
      OFS_AXIS: rd_val = axis_select;
      OFS_TPOS: rd_val = target_position_operand;
      OFS_TSPD: rd_val = target_speed_operand;
      OFS_DWELL: rd_val = dwell_time_operand;
      OFS_AUX: rd_val = aux_code_operand;
      OFS_CTRL: rd_val = control_word_operand;
      OFS_STATUS: rd_val = status;
      OFS_ERRCODE: rd_val = {16'h0000, err_code[1], err_code[0]};
      OFS_POS_X: rd_val = cur_pos[0];
      OFS_POS_Y: rd_val = cur_pos[1];
      OFS_AUX_OUT: rd_val = {aux_out[1], aux_out[0]};
      OFS_BIAS: rd_val = bias_speed;
      OFS_LIMIT: rd_val = speed_limit;
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : fods_top
`default_nettype wire

// [sim/fods_props.sv]
// checker: bus handshakes and X-axis step spacing (step_pulse[0] only) seen at fods_top ports
// bound onto fods_top; one clock, ce held high by the bench
`timescale 1ns/1ps
`default_nettype none
module fods_props
  import fods_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] step_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_wr_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rd_unmapped: assert property (s_rd_take ##0 (s_axi_araddr > 8'h37)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while response pending");
  a_step_gap: assert property (step_pulse[0] |=> (!step_pulse[0]) [*8])
    else $error("step pulses too close");
endmodule : fods_props
bind fods_top fods_props u_props (.aclk, .aresetn, .ce, .s_axi_araddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_pulse);
`default_nettype wire

// [sim/fods_ctrl.sv]
// controller model: register bus master and scan boundary pulses
// tasks are called from the bench top, always just after an edge
`timescale 1ns/1ps
`default_nettype none
module fods_ctrl
  import fods_pkg::*;
#(
  parameter int SCAN = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic scan_tick,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int scan_cnt = 0;
  initial begin
    scan_tick = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
  end
  always @(posedge aclk) begin
    scan_cnt <= (!aresetn || scan_cnt == SCAN - 1) ? 0 : scan_cnt + 1;
    scan_tick <= aresetn && scan_cnt == SCAN - 1;
  end
  // released lines show the inverse, never the value just taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : fods_ctrl
`default_nettype wire

// [sim/test_floating_origin_direct_start.sv]
// bench: controller model drives fods_top, scenarios judge readback
// assumes a 4-cycle millisecond and a 40-cycle controller scan
`timescale 1ns/1ps
`default_nettype none
module test_floating_origin_direct_start
  import fods_pkg::*;
;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] FLAGS = 32'h0000_0bb1;  // instr, busy/err/org
  logic aclk, aresetn, scan_tick, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, step_pulse, step_dir, rr;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int steps_x = 0;
  int base;
  fods_ctrl u_ctrl (.aclk, .aresetn, .scan_tick, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fods_top #(.MS_CYCLES(4)) dut (.aclk, .aresetn, .ce(1'b1), .scan_tick,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_pulse, .step_dir);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (step_pulse[0] === 1'b1) steps_x <= steps_x + 1;
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ctrl.wr(a, d, rr);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    u_ctrl.rd(a, rv, rr);
    check(rv & m, e);
  endtask : rdc
  // bounded status poll; the last read is judged
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 2000; i++) begin
      u_ctrl.rd(OFS_STATUS, rv, rr);
      if (rv[b] === v) break;
    end
    check(32'(rv[b]), 32'(v));
  endtask : poll
  task automatic t_regs;
    rdc(OFS_BIAS, ALL, 32'h0000_0001);
    rdc(OFS_LIMIT, ALL, 32'h0001_86a0);
    u_ctrl.rd(8'h40, rv, rr);
    check(32'(rr), 32'(RESP_SLVERR));
    u_ctrl.wr(OFS_POS_X, 32'h0000_0007, rr);
    check(32'(rr), 32'(RESP_SLVERR));
  endtask : t_regs
  task automatic t_bad_axis;
    wr(OFS_AXIS, 32'h0000_0002);
    wr(OFS_CMD, 32'h0000_0003);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0001);
    wr(OFS_AXIS, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0004);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0000);
  endtask : t_bad_axis
  task automatic t_no_origin;
    wr(OFS_TPOS, 32'h0000_0005);
    wr(OFS_TSPD, 32'h0001_86a0);
    wr(OFS_DWELL, 32'h0000_0001);
    wr(OFS_AUX, 32'h0000_007b);
    wr(OFS_CTRL, 32'h0000_0040);
    wr(OFS_CMD, 32'h0000_0002);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0020);
    rdc(OFS_ERRCODE, 32'h0000_00ff, 32'h0000_00e0);
    check(32'(steps_x), 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0004);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0000);
  endtask : t_no_origin
  task automatic t_move;
    wr(OFS_AXIS, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0001);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0800);
    wr(OFS_AXIS, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0800);
    wr(OFS_CMD, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    rdc(OFS_STATUS, FLAGS, 32'h0000_0880);
    base = steps_x;
    wr(OFS_CMD, 32'h0000_0003);
    rdc(OFS_AUX_OUT, 32'h0000_ffff, 32'h0000_0000);
    poll(AX_BASE + AX_FIN, 1'b1);
    rdc(OFS_POS_X, ALL, 32'h0000_0005);
    check(32'(steps_x - base), 32'h0000_0005);
    rdc(OFS_AUX_OUT, 32'h0000_ffff, 32'h0000_007b);
    rdc(OFS_STATUS, 32'h0003_0010, 32'h0002_0000);
    while (scan_tick !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    rdc(OFS_STATUS, 32'h0000_0040, 32'h0000_0000);
    wr(OFS_TPOS, 32'hffff_fffe);
    wr(OFS_CTRL, 32'h0000_0010);
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0003);
    poll(AX_BASE + AX_FIN, 1'b1);
    rdc(OFS_POS_X, ALL, 32'h0000_0003);
    wr(OFS_CMD, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    rdc(OFS_POS_X, ALL, 32'h0000_0000);
  endtask : t_move
  // absolute -2 would end well inside 300 cycles under position control
  task automatic t_speed;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0003);
    repeat (300) @(posedge aclk);
    rdc(OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    check(32'(step_dir[0]), 32'h0000_0000);
    rdc(OFS_POS_X, 32'h8000_0000, 32'h8000_0000);
    wr(OFS_CMD, 32'h0000_000b);
    poll(AX_BASE + AX_BUSY, 1'b0);
  endtask : t_speed
  initial begin
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_bad_axis();
    t_no_origin();
    t_move();
    t_speed();
    stop_test();
  end
endmodule : test_floating_origin_direct_start
`default_nettype wire
